// ===== hw/owcp_port.sv
// One-wire command port, device side: framing, read/write, control regs.
// Assumes the pin is synchronous to mclk_in and the master keeps its rules.
//
// Overview of operation
// - Device drives low for slave takeover time
// - Device sends addressed 16-bit word, two bytes
// - Device sends zero handover, releases at 3/4
// - Both drive low together during takeover
// - No master takeover: rise is stop, else timeout
// - Entry window after reset, else analog run
// - Analog driven until command mode, then digital
// - Unlock key accepted also in diagnostic mode
// - CRC poly 0x107, preset FFh, XOR at x8
// - Control bit 14 forces diagnostic off
// - Bit 15 reports raw diagnostic condition
// - Bits 8 and 7 sticky EDC flags
// - Bit 6 sticky field loss, needs enable
// - Bit 4 start-up checksum fail, bit 12 undervoltage
// - Command: region 7:5, address 4:1, rw bit 0
// - No rising edge within timeout: back to idle
// - Pulse width coding, MSB byte first
// - Command mode lasts until power-on reset
`timescale 1ns/1ns
`include "owcp_defs.svh"

module owcp_port (
  // Clock and power-on reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // One-wire pin
  input  wire logic        owi_in,
  output logic             owi_out,
  output logic             owi_oe_out,
  // Analog path control and status from the sensor core
  output logic             analog_en_out,
  output logic             cmd_mode_out,
  output logic             diag_out,
  input  wire logic        diag_cond_in,
  input  wire logic        undervoltage_in,
  input  wire logic        edc_fixed_in,
  input  wire logic        edc_fatal_in,
  input  wire logic        nvm_read_in,
  input  wire logic        field_lost_in,
  input  wire logic        field_det_en_in,
  input  wire logic        crc_bad_in,
  // Non-volatile memory access
  output logic [3:0]       nvm_addr_out,
  input  wire logic [15:0] nvm_rdata_in,
  output logic             nvm_we_out,
  output logic [15:0]      nvm_wdata_out,
  output logic             pump_clock_on_out,
  output logic             nvm_write_permit_out,
  // Checksum helper, for loading words into the CRC engine
  input  wire logic        crc_clr_in,
  input  wire logic        crc_feed_in,
  input  wire logic [15:0] crc_word_in,
  output logic [7:0]       crc_out
);

  owcp_pkg::owcp_state_e state_q;
  logic        pin_q;
  logic [15:0] tmr_q;
  logic [31:0] idle_q;
  logic [31:0] win_q;
  logic [4:0]  bitn_q;
  logic [7:0]  cmd_q;
  logic [15:0] sh_q;
  logic        drive_q;
  logic        cmd_mode_q;
  logic        diag_supp_q;
  logic        pump_q;
  logic        permit_q;
  logic        edc_fix_q;
  logic        edc_fat_q;
  logic        flost_q;
  logic [7:0]  crc_q;
  logic [15:0] rd_word;

  wire rise = owi_in & ~pin_q;
  wire fall = ~owi_in & pin_q;
  wire win_open = (win_q != `OWCP_ENTRY_WIN);

  // One CRC step over a 16-bit word, MSB first
  function automatic logic [7:0] crc_word(input logic [7:0] c,
                                          input logic [15:0] d);
    logic [8:0] r;
    r = {1'b0, c};
    for (int i = 15; i >= 0; i--)
    begin
      r = {r[7:0], d[i]};
      if (r[8])
        r = {1'b0, r[7:0] ^ `OWCP_CRC_POLY};
    end
    return r[7:0];
  endfunction : crc_word

  function automatic logic is_reg(input logic [7:0] c,
                                  input logic [3:0] a);
    return (c[7:5] == `OWCP_REG_REGION) && (c[4:1] == a);
  endfunction : is_reg

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (cmd_q[7:5] == `OWCP_EEP_REGION)
      rd_word = nvm_rdata_in;
    else if (is_reg(cmd_q, `OWCP_ADDR_CTRL))
    begin
      rd_word[`OWCP_B_DIAG]   = diag_cond_in;
      rd_word[`OWCP_B_SUPP]   = diag_supp_q;
      rd_word[`OWCP_B_UV]     = undervoltage_in;
      rd_word[`OWCP_B_PUMP]   = pump_q;
      rd_word[`OWCP_B_EDCFIX] = edc_fix_q;
      rd_word[`OWCP_B_EDCFAT] = edc_fat_q;
      rd_word[`OWCP_B_FLOST]  = flost_q;
      rd_word[`OWCP_B_CRCBAD] = crc_bad_in;
    end
    else if (is_reg(cmd_q, `OWCP_ADDR_PERMIT))
      rd_word = permit_q ? `OWCP_PERMIT_ON : `OWCP_PERMIT_OFF;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      pin_q <= 1'b0;
    else
      pin_q <= owi_in;
  end

  // Entry window counter after power-on reset
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      win_q <= 32'h0000_0000;
    else if (win_open)
      win_q <= win_q + 32'h0000_0001;
  end

  // Timeout on absence of rising edges
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || rise || state_q == owcp_pkg::ST_IDLE)
      idle_q <= 32'h0000_0000;
    else if (idle_q != `OWCP_TIMEOUT)
      idle_q <= idle_q + 32'h0000_0001;
  end

  // Link state machine
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= owcp_pkg::ST_IDLE;
      tmr_q   <= 16'h0000;
      bitn_q  <= 5'd0;
      cmd_q   <= 8'h00;
      sh_q    <= 16'h0000;
      drive_q <= 1'b0;
    end
    else if (idle_q == `OWCP_TIMEOUT && !drive_q)
    begin
      state_q <= owcp_pkg::ST_IDLE;
      tmr_q   <= 16'h0000;
    end
    else
    begin
      tmr_q <= tmr_q + 16'h0001;
      case (state_q)
        owcp_pkg::ST_IDLE:
          if (rise)
          begin
            state_q <= owcp_pkg::ST_CMD;
            bitn_q  <= 5'd0;
            tmr_q   <= 16'h0000;
          end
        owcp_pkg::ST_CMD, owcp_pkg::ST_WDATA:
        begin
          if (rise)
            tmr_q <= 16'h0000;
          if (fall)
          begin
            if (state_q == owcp_pkg::ST_CMD)
              cmd_q <= {cmd_q[6:0], tmr_q >= `OWCP_BIT_HALF};
            else
              sh_q <= {sh_q[14:0], tmr_q >= `OWCP_BIT_HALF};
            bitn_q <= bitn_q + 5'd1;
            if (state_q == owcp_pkg::ST_CMD && bitn_q == 5'd7)
            begin
              bitn_q  <= 5'd0;
              // The read/write select is the bit sampled on this very fall
              state_q <= (tmr_q >= `OWCP_BIT_HALF) ? owcp_pkg::ST_HAND_IN
                                                   : owcp_pkg::ST_WDATA;
            end
            if (state_q == owcp_pkg::ST_WDATA && bitn_q == 5'd15)
              state_q <= owcp_pkg::ST_WAIT_STOP;
          end
        end
        owcp_pkg::ST_HAND_IN:
          if (fall)
          begin
            state_q <= owcp_pkg::ST_TAKE;
            tmr_q   <= 16'h0000;
            drive_q <= 1'b1;
          end
        owcp_pkg::ST_TAKE:
          if (tmr_q == `OWCP_TKO_SLV)
          begin
            state_q <= owcp_pkg::ST_RDATA;
            tmr_q   <= 16'h0000;
            bitn_q  <= 5'd0;
            sh_q    <= rd_word;
          end
        owcp_pkg::ST_RDATA:
          if (tmr_q == `OWCP_BIT_CYC - 16'h0001)
          begin
            tmr_q  <= 16'h0000;
            sh_q   <= {sh_q[14:0], 1'b0};
            bitn_q <= bitn_q + 5'd1;
            if (bitn_q == 5'd15)
              state_q <= owcp_pkg::ST_HAND_OUT;
          end
        owcp_pkg::ST_HAND_OUT:
          if (tmr_q == `OWCP_BIT_3Q)
          begin
            drive_q <= 1'b0;
            state_q <= owcp_pkg::ST_WAIT_STOP;
          end
        owcp_pkg::ST_WAIT_STOP:
          if (rise)
            state_q <= owcp_pkg::ST_IDLE;
        default:
          state_q <= owcp_pkg::ST_IDLE;
      endcase
    end
  end

  // Pulse-width encoded output: high first, low for the rest of the bit
  always_comb
  begin
    owi_out = 1'b0;
    if (state_q == owcp_pkg::ST_RDATA)
      owi_out = (tmr_q < (sh_q[15] ? `OWCP_ONE_HI : `OWCP_ZERO_HI));
    else if (state_q == owcp_pkg::ST_HAND_OUT)
      owi_out = (tmr_q < `OWCP_ZERO_HI);
  end
  assign owi_oe_out = drive_q;

  wire wr_done = state_q == owcp_pkg::ST_WDATA && fall && bitn_q == 5'd15;
  wire [15:0] wr_word = {sh_q[14:0], tmr_q >= `OWCP_BIT_HALF};

  // Command mode entry and control registers
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cmd_mode_q  <= 1'b0;
      diag_supp_q <= 1'b0;
      pump_q      <= 1'b0;
      permit_q    <= 1'b0;
    end
    else if (wr_done)
    begin
      if (is_reg(cmd_q, `OWCP_ADDR_KEY) && wr_word == `OWCP_UNLOCK_KEY
          && (win_open || diag_cond_in))
        cmd_mode_q <= 1'b1;
      if (cmd_mode_q && is_reg(cmd_q, `OWCP_ADDR_CTRL))
      begin
        diag_supp_q <= wr_word[`OWCP_B_SUPP];
        pump_q      <= wr_word[`OWCP_B_PUMP];
      end
      if (cmd_mode_q && is_reg(cmd_q, `OWCP_ADDR_PERMIT))
        permit_q <= wr_word[`OWCP_B_PERMIT];
    end
  end

  // Sticky error flags; a set is never lost
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      edc_fix_q <= 1'b0;
      edc_fat_q <= 1'b0;
      flost_q   <= 1'b0;
    end
    else
    begin
      if (nvm_read_in && edc_fixed_in)
        edc_fix_q <= 1'b1;
      if (nvm_read_in && edc_fatal_in)
        edc_fat_q <= 1'b1;
      if (field_lost_in && field_det_en_in)
        flost_q <= 1'b1;
    end
  end

  // Checksum engine for software-fed words
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || crc_clr_in)
      crc_q <= `OWCP_CRC_INIT;
    else if (crc_feed_in)
      crc_q <= crc_word(crc_q, crc_word_in);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      nvm_we_out    <= 1'b0;
      nvm_wdata_out <= 16'h0000;
    end
    else
    begin
      nvm_we_out <= wr_done && cmd_mode_q && permit_q && pump_q
                    && cmd_q[7:5] == `OWCP_EEP_REGION;
      if (wr_done)
        nvm_wdata_out <= wr_word;
    end
  end

  // Analog stays driven until command mode is reached
  assign analog_en_out        = ~cmd_mode_q;
  assign cmd_mode_out         = cmd_mode_q;
  assign diag_out             = diag_cond_in & ~diag_supp_q;
  assign nvm_addr_out         = cmd_q[4:1];
  assign pump_clock_on_out    = pump_q;
  assign nvm_write_permit_out = permit_q;
  assign crc_out              = crc_q;

endmodule : owcp_port

// ===== hw/owcp_defs.svh
// Constants for the one-wire command port: timing, keys, field positions.
// Assumes a 250 MHz core clock; all times are given in clock cycles.
`ifndef OWCP_DEFS_SVH
`define OWCP_DEFS_SVH

`define OWCP_BIT_CYC        16'd1000
`define OWCP_BIT_HALF       16'd500
`define OWCP_BIT_3Q         16'd750
`define OWCP_ONE_HI         16'd750
`define OWCP_ZERO_HI        16'd250
`define OWCP_TKO_SLV        16'd500
`define OWCP_TIMEOUT        32'd100000
`define OWCP_ENTRY_WIN      32'd2500000
`define OWCP_REG_REGION     3'b100
`define OWCP_EEP_REGION     3'b000
`define OWCP_ADDR_CTRL      4'h1
`define OWCP_ADDR_KEY       4'hA
`define OWCP_ADDR_PERMIT    4'hB
`define OWCP_UNLOCK_KEY     16'h9BA4
`define OWCP_PERMIT_OFF     16'h0605
`define OWCP_PERMIT_ON      16'h0E05
`define OWCP_CRC_POLY       8'h07
`define OWCP_CRC_INIT       8'hFF
`define OWCP_B_DIAG         15
`define OWCP_B_SUPP         14
`define OWCP_B_UV           12
`define OWCP_B_PUMP         11
`define OWCP_B_EDCFIX       8
`define OWCP_B_EDCFAT       7
`define OWCP_B_FLOST        6
`define OWCP_B_CRCBAD       4
`define OWCP_B_PERMIT       11

`endif

// ===== hw/owcp_pkg.sv
// Types for the one-wire command port.
// Assumes owcp_defs.svh holds every numeric constant.
package owcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_WDATA, ST_HAND_IN, ST_TAKE, ST_RDATA, ST_HAND_OUT,
    ST_WAIT_STOP
  } owcp_state_e;
endpackage : owcp_pkg

// ===== bench/owcp_port_properties.sv
// Port checker for the one-wire command port.
// Assumes it is bound onto owcp_port and sees its ports only.
`timescale 1ns/1ns
module owcp_port_properties (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       owi_in,
  input wire logic       owi_out,
  input wire logic       owi_oe_out,
  input wire logic       analog_en_out,
  input wire logic       cmd_mode_out,
  input wire logic       diag_out,
  input wire logic       diag_cond_in,
  input wire logic       pump_clock_on_out,
  input wire logic       nvm_write_permit_out,
  input wire logic       crc_clr_in,
  input wire logic       crc_feed_in,
  input wire logic [7:0] crc_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_drive_low;
    owi_oe_out && !owi_out;
  endsequence
  sequence s_handover_low;
    !$past(owi_out) && !$past(owi_out, 8);
  endsequence

  property p_take_low;
    $rose(owi_oe_out) |-> s_drive_low [*8];
  endproperty
  a_take_low: assert property (p_take_low)
    else $error("takeover not driven low");
  // Handover high still seen a few cycles back, so no late takeover
  property p_take_early;
    $rose(owi_oe_out) |-> $past(owi_in, 8);
  endproperty
  a_take_early: assert property (p_take_early)
    else $error("takeover came late");
  property p_release;
    $fell(owi_oe_out) |-> s_handover_low;
  endproperty
  a_release: assert property (p_release)
    else $error("release without low handover tail");
  property p_mode_kept;
    cmd_mode_out |=> cmd_mode_out;
  endproperty
  a_mode_kept: assert property (p_mode_kept)
    else $error("command mode dropped");
  property p_analog_off;
    cmd_mode_out && $past(cmd_mode_out) |-> !analog_en_out;
  endproperty
  a_analog_off: assert property (p_analog_off)
    else $error("analog driver on in command mode");
  property p_analog_on;
    !cmd_mode_out && !$past(cmd_mode_out) |-> analog_en_out;
  endproperty
  a_analog_on: assert property (p_analog_on)
    else $error("analog driver off outside command mode");
  property p_diag_off;
    !diag_cond_in && !$past(diag_cond_in) |-> !diag_out;
  endproperty
  a_diag_off: assert property (p_diag_off)
    else $error("diagnostic without condition");
  property p_pump_mode;
    $rose(pump_clock_on_out) |-> cmd_mode_out;
  endproperty
  a_pump_mode: assert property (p_pump_mode)
    else $error("pump clock set outside command mode");
  property p_permit_mode;
    $rose(nvm_write_permit_out) |-> cmd_mode_out;
  endproperty
  a_permit_mode: assert property (p_permit_mode)
    else $error("write permit set outside command mode");
  property p_crc_preset;
    crc_clr_in && !crc_feed_in |=> crc_out == 8'hff;
  endproperty
  a_crc_preset: assert property (p_crc_preset)
    else $error("checksum preset wrong");
endmodule : owcp_port_properties

bind owcp_port owcp_port_properties i_props (.*);

// ===== bench/owcp_master.sv
// Programming master model on the one-wire pin.
// Assumes the bench resolves the pin from both enables with a pull-up.
`timescale 1ns/1ns
module owcp_master (
  // Clock and resolved pin
  input  wire logic mclk_in,
  input  wire logic owi_in,
  // Master drive
  output logic      m_oe_out,
  output logic      m_val_out
);
  initial
  begin
    m_oe_out  = 1'b1;
    m_val_out = 1'b0;
  end

  task automatic drive(input logic v, input int n);
    @(posedge mclk_in);
    m_val_out <= v;
    repeat (n - 1) @(posedge mclk_in);
  endtask : drive

  // Start rise opens the first bit; long high is one, short is zero
  task automatic send(input logic [23:0] v, input int n);
    drive(1'b0, 100);
    for (int i = n - 1; i >= 0; i--)
    begin
      drive(1'b1, v[i] ? 750 : 250);
      drive(1'b0, v[i] ? 250 : 750);
    end
  endtask : send

  task automatic write_frame(input logic [7:0] cmd, input logic [15:0] d);
    send({cmd, d}, 24);
    drive(1'b1, 100);
  endtask : write_frame

  task automatic read_frame(input logic [7:0] cmd, output logic [16:0] d);
    int hi;
    send({16'h0000, cmd}, 8);
    drive(1'b1, 250);
    drive(1'b0, 500);
    @(posedge mclk_in);
    m_oe_out <= 1'b0;
    for (int i = 0; i < 17; i++)
    begin
      hi = 0;
      while (!owi_in) @(posedge mclk_in);
      while (owi_in)
      begin
        hi++;
        @(posedge mclk_in);
      end
      d = {d[15:0], hi >= 500};
    end
    // Low at once on the handover fall, overlapping the device drive
    m_oe_out <= 1'b1;
    drive(1'b0, 600);
    drive(1'b1, 100);
  endtask : read_frame
endmodule : owcp_master

// ===== bench/owcp_port_tb.sv
// Bench for the one-wire command port: status, frames and checksum.
// Assumes owcp_master on the pin and a pull-up on the line.
`timescale 1ns/1ns
module owcp_port_tb;
  logic        mclk_in = 1'b0;
  logic        rst_n_in, diag_cond_in, undervoltage_in, edc_fixed_in;
  logic        edc_fatal_in, nvm_read_in, field_lost_in, crc_bad_in;
  logic        field_det_en_in, crc_clr_in, crc_feed_in, nvm_we_out;
  logic        owi_out, owi_oe_out, analog_en_out, cmd_mode_out, diag_out;
  logic        pump_clock_on_out, nvm_write_permit_out, m_oe_out, m_val_out;
  logic [15:0] crc_word_in, nvm_rdata_in, nvm_wdata_out, exp_word;
  logic [7:0]  crc_out, exp_crc;
  logic [3:0]  nvm_addr_out;
  logic [16:0] rd;
  int          mismatches, n_compared;
  wire         owi_in;

  // Released line floats to the pull-up
  assign owi_in = owi_oe_out ? owi_out : (m_oe_out ? m_val_out : 1'b1);
  always #2 mclk_in = ~mclk_in;
  owcp_port i_dut (.*);
  owcp_master i_mst (.*);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  function automatic logic [7:0] fold(input logic [7:0] c,
                                      input logic [15:0] w);
    logic [8:0] t;
    for (int i = 15; i >= 0; i--)
    begin
      t = {c, w[i]};
      if (t[8])
        t ^= 9'h107;
      c = t[7:0];
    end
    return c;
  endfunction : fold

  // Words fed back to back to catch a dropped fold
  task automatic crc_pass(input bit rnd);
    logic [15:0] w;
    exp_crc = 8'hff;
    @(posedge mclk_in);
    crc_clr_in <= 1'b1;
    @(posedge mclk_in);
    crc_clr_in <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      w = rnd ? 16'($urandom) : (i < 15 ? 16'((i + 1) * 'h1111) : 16'h4200);
      exp_crc = fold(exp_crc, w);
      crc_feed_in <= 1'b1;
      crc_word_in <= w;
      @(posedge mclk_in);
    end
    crc_feed_in <= 1'b0;
    @(negedge mclk_in);
    check(crc_out, exp_crc);
  endtask : crc_pass

  initial
  begin
    void'($urandom(32'hca7f_58e8));
    {rst_n_in, diag_cond_in, undervoltage_in, edc_fixed_in} = 4'h0;
    {edc_fatal_in, nvm_read_in, field_lost_in, crc_bad_in} = 4'h0;
    {crc_clr_in, crc_feed_in, field_det_en_in} = 3'h1;
    crc_word_in = 16'h0000;
    nvm_rdata_in = 16'h0000;
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    check(analog_en_out, 1'b1);
    check({cmd_mode_out, pump_clock_on_out, nvm_write_permit_out}, 3'h0);
    crc_pass(1'b0);
    crc_pass(1'b1);
    i_mst.write_frame(8'h94, 16'h9ba4);
    @(negedge mclk_in);
    check({cmd_mode_out, analog_en_out}, 2'h2);
    @(posedge mclk_in);
    diag_cond_in <= 1'b1;
    edc_fatal_in <= 1'b1;
    {undervoltage_in, crc_bad_in} <= 2'($urandom);
    {edc_fixed_in, nvm_read_in, field_lost_in} <= 3'h7;
    @(posedge mclk_in);
    {edc_fixed_in, nvm_read_in, field_lost_in} <= 3'h0;
    @(negedge mclk_in);
    check(diag_out, 1'b1);
    i_mst.write_frame(8'h96, 16'h0e05);
    i_mst.write_frame(8'h82, 16'h4800);
    @(negedge mclk_in);
    check({pump_clock_on_out, nvm_write_permit_out, diag_out}, 3'h6);
    i_mst.read_frame(8'h83, rd);
    @(negedge mclk_in);
    exp_word = {2'b11, 1'b0, undervoltage_in, 4'h9, 2'h3, 1'b0, crc_bad_in,
                4'h0};
    check(rd[16:1], exp_word);
    check(rd[0], 1'b0);
    check(nvm_addr_out, 4'h1);
    final_report();
  end

  initial
  begin
    repeat (120000) @(posedge mclk_in);
    mismatches++;
    final_report();
  end
endmodule : owcp_port_tb
